// >>> src/acc_comparator_ctrl.sv
// Chosen here: the APB interface to the registers.
`timescale 1ns/10ps
// ----------------------------------------------------------------
// analog comparator control
// ----------------------------------------------------------------
module acc_comparator_ctrl (
   // clock and reset
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   // apb slave
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [acc_pkg::ADDR_W-1:0] paddr,
   input  wire logic [acc_pkg::DATA_W-1:0] pwdata,
   output      logic                       pready,
   output      logic [acc_pkg::DATA_W-1:0] prdata,
   output      logic                       pslverr,
   // converter block state, same clock
   input  wire logic                       converter_enable,
   input  wire logic [2:0]                 channel_select,
   output      logic [2:0]                 converter_trigger_select,
   // core interrupt handshake
   input  wire logic                       global_int_enable,
   input  wire logic                       vector_ack,
   output      logic                       comparator_irq_req,
   output      logic                       irq,
   // analog comparator front end
   input  wire logic                       comparator_raw,
   output      logic                       comparator_power_off,
   output      logic                       pos_bandgap_sel,
   output      logic                       neg_pin_sel,
   output      logic                       neg_channel_en,
   output      logic [2:0]                 neg_channel_sel,
   // comparator pins, digital side
   input  wire logic [1:0]                 pin_digital_in,
   output      logic [1:0]                 input_buffer_disable,
   output      logic [1:0]                 port_pin_read,
   // timer input capture front end
   output      logic                       capture_route_en,
   output      logic                       capture_input
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------

   typedef struct packed {
      logic [7:0]                csr;
      logic [7:0]                conv;
      logic [acc_pkg::IBD_W-1:0] ibd;
      logic [acc_pkg::IST_W-1:0] ist;
      logic [acc_pkg::IST_W-1:0] imsk;
      logic [acc_pkg::DATA_W-1:0] rdata;
   } acc_ctl_s;

   acc_ctl_s st_r;
   acc_ctl_s st_nxt;

   // ----------------------------------------------------------------
   // internal signals
   // ----------------------------------------------------------------

   logic                       raw_sync;
   logic [1:0]                 pin_sync;
   logic                       cmp_out;
   logic                       cmp_event;
   logic                       toggle_event;
   logic                       mux_lend;
   logic [acc_pkg::IDX_W-1:0]  word_idx;
   logic                       hit_csr;
   logic                       hit_conv;
   logic                       hit_ibd;
   logic                       hit_ist;
   logic                       hit_imsk;
   logic                       mapped;
   logic                       setup;
   logic                       wr_acc;
   logic [acc_pkg::DATA_W-1:0] rd_mux;
   logic [7:0]                 csr_view;

   // ----------------------------------------------------------------
   // synchronisers
   // ----------------------------------------------------------------

   // raw comparator output crosses from the analog side
   acc_sync #(
      .W (1)
   ) u_sync_raw (
      .clk   (pclk),
      .rst_n (presetn),
      .d     (comparator_raw),
      .q     (raw_sync)
   );

   // pin levels are asynchronous too
   acc_sync #(
      .W (2)
   ) u_sync_pin (
      .clk   (pclk),
      .rst_n (presetn),
      .d     (pin_digital_in),
      .q     (pin_sync)
   );

   // ----------------------------------------------------------------
   // comparator output and events
   // ----------------------------------------------------------------

   // a powered down comparator reads low; the drop can flag an event,
   // so software disables the interrupt first
   assign cmp_out = raw_sync & ~st_r.csr[acc_pkg::CSR_PWROFF_B];

   // event detector on the mode that software selected
   acc_edge_det u_edge_mode (
      .clk     (pclk),
      .rst_n   (presetn),
      .level   (cmp_out),
      .mode    (acc_pkg::acc_edge_mode_e'(
                st_r.csr[acc_pkg::CSR_MODE_HI:acc_pkg::CSR_MODE_LO])),
      .event_p (cmp_event)
   );

   // second detector feeds the toggle bit of the interrupt status
   acc_edge_det u_edge_toggle (
      .clk     (pclk),
      .rst_n   (presetn),
      .level   (cmp_out),
      .mode    (acc_pkg::ACC_MODE_TOGGLE),
      .event_p (toggle_event)
   );

   // ----------------------------------------------------------------
   // input selection
   // ----------------------------------------------------------------

   // the converter mux is only lent while the converter is off
   assign mux_lend = st_r.conv[acc_pkg::CONV_MUXEN_B]
                   & ~converter_enable;

   // negative input: borrowed channel or dedicated pin
   assign neg_channel_en  = mux_lend;
   assign neg_channel_sel = mux_lend ? channel_select
                                     : 3'h0;
   assign neg_pin_sel     = ~mux_lend;

   // positive input: bandgap or dedicated pin
   assign pos_bandgap_sel = st_r.csr[acc_pkg::CSR_BG_B];

   // power control, takes effect at once
   assign comparator_power_off =
      st_r.csr[acc_pkg::CSR_PWROFF_B];

   // trigger source bits kept here for the converter block
   assign converter_trigger_select =
      st_r.conv[acc_pkg::CONV_TRIG_HI:acc_pkg::CONV_TRIG_LO];

   // ----------------------------------------------------------------
   // timer capture and pins
   // ----------------------------------------------------------------

   // gated to zero when the route is off, so the timer sees no link
   assign capture_route_en = st_r.csr[acc_pkg::CSR_CAPT_B];
   assign capture_input    = capture_route_en & cmp_out;

   // disabled buffers read as zero at the port
   assign input_buffer_disable = st_r.ibd;
   assign port_pin_read        = pin_sync & ~st_r.ibd;

   // ----------------------------------------------------------------
   // interrupts
   // ----------------------------------------------------------------

   // comparator request towards the core vector logic
   assign comparator_irq_req = st_r.csr[acc_pkg::CSR_FLAG_B]
                             & st_r.csr[acc_pkg::CSR_IE_B]
                             & global_int_enable;

   // summary line from sticky status and its mask
   assign irq = |(st_r.ist & st_r.imsk);

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------

   assign word_idx = paddr[acc_pkg::ADDR_W-1:2];
   assign hit_csr  = (word_idx == acc_pkg::CSR_IDX);
   assign hit_conv = (word_idx == acc_pkg::CONV_IDX);
   assign hit_ibd  = (word_idx == acc_pkg::IBD_IDX);
   assign hit_ist  = (word_idx == acc_pkg::IST_IDX);
   assign hit_imsk = (word_idx == acc_pkg::IMSK_IDX);
   assign mapped   = hit_csr | hit_conv | hit_ibd | hit_ist | hit_imsk;

   // zero wait states; unmapped addresses answer with an error
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign setup   = psel & ~penable;
   assign wr_acc  = psel & penable & pwrite & mapped;
   assign prdata  = st_r.rdata;

   // live view of the control/status byte
   always_comb
   begin
      csr_view                      = st_r.csr;
      csr_view[acc_pkg::CSR_OUT_B]  = cmp_out;
   end

   // read mux, narrow registers sit in the low bits
   always_comb
   begin
      rd_mux = '0;
      if (hit_csr)
         rd_mux[7:0] = csr_view;
      else if (hit_conv)
         rd_mux[7:0] = st_r.conv;
      else if (hit_ibd)
         rd_mux[acc_pkg::IBD_W-1:0] = st_r.ibd;
      else if (hit_ist)
         rd_mux[acc_pkg::IST_W-1:0] = st_r.ist;
      else if (hit_imsk)
         rd_mux[acc_pkg::IST_W-1:0] = st_r.imsk;
      else
         rd_mux = '0;
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------

   // writes first, then clears by hardware, then sets, so a set in the
   // same cycle as any clear always survives
   always_comb
   begin
      st_nxt = st_r;

      // read data captured in the setup phase, held through access
      if (setup)
         st_nxt.rdata = rd_mux;

      // control/status byte; output bit is never stored
      if (wr_acc && hit_csr)
      begin
         st_nxt.csr[acc_pkg::CSR_PWROFF_B] =
            pwdata[acc_pkg::CSR_PWROFF_B];
         st_nxt.csr[acc_pkg::CSR_BG_B]     = pwdata[acc_pkg::CSR_BG_B];
         st_nxt.csr[acc_pkg::CSR_IE_B]     = pwdata[acc_pkg::CSR_IE_B];
         st_nxt.csr[acc_pkg::CSR_CAPT_B]   = pwdata[acc_pkg::CSR_CAPT_B];
         st_nxt.csr[acc_pkg::CSR_MODE_HI:acc_pkg::CSR_MODE_LO] =
            pwdata[acc_pkg::CSR_MODE_HI:acc_pkg::CSR_MODE_LO];
         if (pwdata[acc_pkg::CSR_FLAG_B])
            st_nxt.csr[acc_pkg::CSR_FLAG_B] = 1'b0;
      end
      st_nxt.csr[acc_pkg::CSR_OUT_B] = 1'b0;

      // vector execution clears the flag
      if (vector_ack)
         st_nxt.csr[acc_pkg::CSR_FLAG_B] = 1'b0;

      // event sets the flag and wins over any clear
      if (cmp_event)
         st_nxt.csr[acc_pkg::CSR_FLAG_B] = 1'b1;

      // converter control b: mux enable and trigger source only
      if (wr_acc && hit_conv)
      begin
         st_nxt.conv = 8'h00;
         st_nxt.conv[acc_pkg::CONV_MUXEN_B] =
            pwdata[acc_pkg::CONV_MUXEN_B];
         st_nxt.conv[acc_pkg::CONV_TRIG_HI:acc_pkg::CONV_TRIG_LO] =
            pwdata[acc_pkg::CONV_TRIG_HI:acc_pkg::CONV_TRIG_LO];
      end

      // input buffer disables
      if (wr_acc && hit_ibd)
         st_nxt.ibd = pwdata[acc_pkg::IBD_W-1:0];

      // interrupt mask
      if (wr_acc && hit_imsk)
         st_nxt.imsk = pwdata[acc_pkg::IST_W-1:0];

      // sticky status, write one to clear
      if (wr_acc && hit_ist)
         st_nxt.ist = st_r.ist & ~pwdata[acc_pkg::IST_W-1:0];
      if (cmp_event)
         st_nxt.ist[acc_pkg::IST_EVENT_B] = 1'b1;
      if (toggle_event)
         st_nxt.ist[acc_pkg::IST_TOGGLE_B] = 1'b1;
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r.csr   <= acc_pkg::CSR_RST;
         st_r.conv  <= acc_pkg::CONV_RST;
         st_r.ibd   <= acc_pkg::IBD_RST;
         st_r.ist   <= acc_pkg::IST_RST;
         st_r.imsk  <= acc_pkg::IMSK_RST;
         st_r.rdata <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

endmodule

// >>> src/acc_edge_det.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// edge and toggle detector on a synchronised level
// ----------------------------------------------------------------
module acc_edge_det (
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   // level and selected event kind
   input  wire logic                    level,
   input  wire acc_pkg::acc_edge_mode_e mode,
   // one cycle event pulse
   output      logic                    event_p
);

   typedef struct packed {
      logic prev;
      logic primed;
   } acc_edge_s;

   acc_edge_s st_r;
   acc_edge_s st_nxt;
   logic      rise;
   logic      fall;

   // primed bit stops a high level after reset looking like a rise
   always_comb
   begin
      st_nxt        = st_r;
      st_nxt.prev   = level;
      st_nxt.primed = 1'b1;
   end

   // state register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   // compare with the value one clock earlier
   assign rise = st_r.primed & level & ~st_r.prev;
   assign fall = st_r.primed & ~level & st_r.prev;

   // mode decode, the reserved code never flags
   always_comb
   begin
      unique case (mode)
         acc_pkg::ACC_MODE_TOGGLE: event_p = rise | fall;
         acc_pkg::ACC_MODE_RSVD:   event_p = 1'b0;
         acc_pkg::ACC_MODE_FALL:   event_p = fall;
         acc_pkg::ACC_MODE_RISE:   event_p = rise;
      endcase
   end

endmodule

// >>> src/acc_pkg.sv
// ----------------------------------------------------------------
// shared constants of the comparator control block
// ----------------------------------------------------------------
package acc_pkg;

   // bus geometry
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned IDX_W  = 10;

   // register indices, byte address is four times the index
   localparam logic [IDX_W-1:0] CSR_IDX  = 10'h050;
   localparam logic [IDX_W-1:0] CONV_IDX = 10'h07b;
   localparam logic [IDX_W-1:0] IBD_IDX  = 10'h060;
   localparam logic [IDX_W-1:0] IST_IDX  = 10'h061;
   localparam logic [IDX_W-1:0] IMSK_IDX = 10'h062;

   // comparator control/status field positions
   localparam int unsigned CSR_PWROFF_B = 7;
   localparam int unsigned CSR_BG_B     = 6;
   localparam int unsigned CSR_OUT_B    = 5;
   localparam int unsigned CSR_FLAG_B   = 4;
   localparam int unsigned CSR_IE_B     = 3;
   localparam int unsigned CSR_CAPT_B   = 2;
   localparam int unsigned CSR_MODE_HI  = 1;
   localparam int unsigned CSR_MODE_LO  = 0;

   // converter control b field positions
   localparam int unsigned CONV_MUXEN_B = 6;
   localparam int unsigned CONV_TRIG_HI = 2;
   localparam int unsigned CONV_TRIG_LO = 0;

   // input buffer disable, interrupt status and mask layouts
   localparam int unsigned IBD_W        = 2;
   localparam int unsigned IBD_POS_B    = 0;
   localparam int unsigned IBD_NEG_B    = 1;
   localparam int unsigned IST_W        = 2;
   localparam int unsigned IST_EVENT_B  = 0;
   localparam int unsigned IST_TOGGLE_B = 1;

   // values after reset
   localparam logic [7:0]       CSR_RST  = 8'h00;
   localparam logic [7:0]       CONV_RST = 8'h00;
   localparam logic [IBD_W-1:0] IBD_RST  = 2'h0;
   localparam logic [IST_W-1:0] IST_RST  = 2'h0;
   localparam logic [IST_W-1:0] IMSK_RST = 2'h0;

   // cycle counts
   localparam int unsigned SYNC_STAGES = 2;

   // event modes of the comparator event flag
   typedef enum logic [1:0] {
      ACC_MODE_TOGGLE = 2'h0,
      ACC_MODE_RSVD   = 2'h1,
      ACC_MODE_FALL   = 2'h2,
      ACC_MODE_RISE   = 2'h3
   } acc_edge_mode_e;

endpackage

// >>> src/acc_sync.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// two flop synchroniser for asynchronous levels
// ----------------------------------------------------------------
module acc_sync #(
   parameter int unsigned W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // asynchronous level in, synchronised level out
   input  wire logic [W-1:0] d,
   output      logic [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] stage2;
      logic [W-1:0] stage1;
   } acc_sync_s;

   acc_sync_s st_r;
   acc_sync_s st_nxt;

   // first stage feeds only the second one
   always_comb
   begin
      st_nxt        = st_r;
      st_nxt.stage1 = d;
      st_nxt.stage2 = st_r.stage1;
   end

   // state register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign q = st_r.stage2;

endmodule

// >>> tb/acc_analog_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// analog core, comparator pins and timer capture front end
// ----------------------------------------------------------------
module acc_analog_model #(
   parameter logic [7:0] BANDGAP = 8'h5a
) (
   // clock
   input  wire logic            pclk,
   // voltages coded 00 to ff
   input  wire logic [7:0]      v_pos,
   input  wire logic [7:0]      v_neg,
   input  wire logic [7:0][7:0] v_ch,
   // selections from the control block
   input  wire logic            power_off,
   input  wire logic            bandgap_sel,
   input  wire logic            neg_pin_sel,
   input  wire logic [2:0]      neg_channel_sel,
   input  wire logic            capture_input,
   // comparator result, pin levels, capture count
   output      logic            comparator_raw,
   output      logic [1:0]      pin_digital_in,
   output      int              cap_edges
);
   logic [7:0] pos;
   logic [7:0] neg;
   logic       cap_q;

   // input selection
   assign pos = bandgap_sel ? BANDGAP : v_pos;
   assign neg = neg_pin_sel ? v_neg : v_ch[neg_channel_sel];
   // an unpowered core gives a low result
   assign comparator_raw = !power_off && (pos > neg);
   // digital side sees the top bit of the pin voltage
   assign pin_digital_in = {v_neg[7], v_pos[7]};

   // capture front end counts rising edges only
   always @(posedge pclk)
   begin
      cap_q <= capture_input;
      if (capture_input && !cap_q)
         cap_edges <= cap_edges + 1;
   end
endmodule

// >>> tb/acc_comparator_ctrl_props.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// port level checks of the comparator control
// ----------------------------------------------------------------
module acc_comparator_ctrl_props (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   // converter, interrupt, analog front end
   input wire logic        converter_enable,
   input wire logic [2:0]  channel_select,
   input wire logic        global_int_enable,
   input wire logic        comparator_irq_req,
   input wire logic        comparator_raw,
   input wire logic        comparator_power_off,
   input wire logic        pos_bandgap_sel,
   input wire logic        neg_pin_sel,
   input wire logic        neg_channel_en,
   input wire logic [2:0]  neg_channel_sel,
   // pins and timer capture
   input wire logic [1:0]  pin_digital_in,
   input wire logic [1:0]  input_buffer_disable,
   input wire logic [1:0]  port_pin_read,
   input wire logic        capture_route_en,
   input wire logic        capture_input
);
   localparam logic [11:0] CSR_A = {acc_pkg::CSR_IDX, 2'h0};
   localparam logic [11:0] IBD_A = {acc_pkg::IBD_IDX, 2'h0};

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // ----------------------------------------------------------------
   // sequences
   // ----------------------------------------------------------------
   sequence csr_wr_s;
      psel && penable && pwrite && paddr == CSR_A;
   endsequence
   sequence ibd_rd_s;
      psel && penable && !pwrite && paddr == IBD_A;
   endsequence
   // sync chain only trusted after three settled cycles
   sequence routed_s;
      (capture_route_en && !comparator_power_off)[*3];
   endsequence

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   pwr_off_a: assert property (csr_wr_s |=> comparator_power_off == $past(pwdata[7]))
      else $error("power off differs from written bit");
   bg_sel_a: assert property (csr_wr_s |=> pos_bandgap_sel == $past(pwdata[6]))
      else $error("bandgap select differs from written bit");
   route_en_a: assert property (csr_wr_s |=> capture_route_en == $past(pwdata[2]))
      else $error("capture route differs from written bit");
   sync_lat_a: assert property (routed_s |-> capture_input == $past(comparator_raw, 2))
      else $error("capture input not raw output two edges late");
   route_off_a: assert property (!capture_route_en |-> !capture_input)
      else $error("capture input active without route");
   neg_pin_a: assert property (converter_enable |-> neg_pin_sel && !neg_channel_en)
      else $error("mux lent while converter on");
   chan_sel_a: assert property (neg_channel_en |-> neg_channel_sel == channel_select)
      else $error("lent channel differs from channel select");
   irq_gate_a: assert property (comparator_irq_req |-> global_int_enable)
      else $error("request while global enable low");
   pin_gate_a: assert property ((port_pin_read & input_buffer_disable) == 2'h0)
      else $error("disabled pin reads one");
   pin_sync_a: assert property (presetn[*3] |->
      port_pin_read == ($past(pin_digital_in, 2) & ~input_buffer_disable))
      else $error("pin read not synced pin level");
   ibd_zero_a: assert property (ibd_rd_s |-> prdata[31:2] == 30'h0)
      else $error("upper buffer disable bits nonzero");
endmodule

bind acc_comparator_ctrl acc_comparator_ctrl_props u_props (.*);

// >>> tb/acc_comparator_ctrl_tb.sv
`timescale 1ns/10ps
module acc_comparator_ctrl_tb;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   localparam logic [7:0]  BG    = 8'h5a;
   localparam logic [11:0] A_CSR = {acc_pkg::CSR_IDX, 2'h0};
   localparam logic [11:0] A_CNV = {acc_pkg::CONV_IDX, 2'h0};
   localparam logic [11:0] A_IBD = {acc_pkg::IBD_IDX, 2'h0};
   localparam logic [11:0] A_IST = {acc_pkg::IST_IDX, 2'h0};
   localparam logic [11:0] A_MSK = {acc_pkg::IMSK_IDX, 2'h0};
   logic            pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
   logic [11:0]     paddr;
   logic [31:0]     pwdata, prdata, q;
   logic            cen, gie, vack, req, irq, raw, poff, bg, npin, nchen, cre, cap;
   logic            m, p, b;
   logic [2:0]      chs, trg, nch;
   logic [1:0]      pins, ibd, ppr;
   logic [7:0]      vp, vn;
   logic [7:0][7:0] vch;
   logic [11:0]     ra [5];
   int              err_count, n_tests, cyc, capn, c0;

   acc_comparator_ctrl u_dut (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
      .prdata, .pslverr, .converter_enable(cen),
      .channel_select(chs), .converter_trigger_select(trg),
      .global_int_enable(gie), .vector_ack(vack), .comparator_irq_req(req),
      .irq(irq), .comparator_raw(raw), .comparator_power_off(poff),
      .pos_bandgap_sel(bg), .neg_pin_sel(npin), .neg_channel_en(nchen),
      .neg_channel_sel(nch), .pin_digital_in(pins), .input_buffer_disable(ibd),
      .port_pin_read(ppr), .capture_route_en(cre), .capture_input(cap));

   acc_analog_model #(.BANDGAP(BG)) u_ana (
      .pclk, .v_pos(vp), .v_neg(vn), .v_ch(vch), .power_off(poff),
      .bandgap_sel(bg), .neg_pin_sel(npin), .neg_channel_sel(nch),
      .capture_input(cap), .comparator_raw(raw), .pin_digital_in(pins),
      .cap_edges(capn));

   // ----------------------------------------------------------------
   // clock, timeout, tasks
   // ----------------------------------------------------------------
   always #2 pclk = ~pclk;

   // a hang ends the run as a mismatch
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         complete_run;
      end
   end

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // one apb transfer; idle edge first so signals never change twice at once
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'h1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do
         @(posedge pclk);
      while (pready !== 1'h1);
      q = prdata;
      serr = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask

   // expected comparator result from the selections made
   function automatic logic exp_out(input logic mx, input logic bs, input logic po);
      return !po && ((bs ? BG : vp) > ((mx && !cen) ? vch[chs] : vn));
   endfunction

   function automatic logic exp_flag(input int md, input logic rise);
      return md == 0 || (md == 3 && rise) || (md == 2 && !rise);
   endfunction

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      pclk = 1'h0;
      presetn = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      cen = 1'h0;
      chs = 3'h0;
      gie = 1'h0;
      vack = 1'h0;
      vp = 8'h00;
      vn = 8'h80;
      vch = 64'h0;
      err_count = 0;
      n_tests = 0;
      cyc = 0;
      void'($urandom(54590));
      ra = '{A_CSR, A_CNV, A_IBD, A_IST, A_MSK};
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
      // reset values, all registers clear
      foreach (ra[i])
      begin
         apb(1'h0, ra[i], 32'h0);
         chk(q, 32'h0);
      end
      // unmapped word refused
      apb(1'h1, 12'hffc, 32'hffffffff);
      chk(32'(serr), 32'h1);
      apb(1'h0, 12'hffc, 32'h0);
      chk(q, 32'h0);
      apb(1'h1, A_CNV, 32'hffffffff);
      apb(1'h0, A_CNV, 32'h0);
      chk(q, 32'h47);
      chk(32'(trg), 32'h7);
      // random input routing, bandgap and power off
      repeat (16)
      begin
         {m, p, b} = 3'($urandom);
         apb(1'h1, A_CNV, {25'h0, m, 6'h0});
         apb(1'h1, A_CSR, {24'h0, p, b, 6'h0});
         {cen, chs} <= 4'($urandom);
         vp <= 8'($urandom);
         vch <= {$urandom, $urandom};
         wt(4);
         chk(32'(bg), 32'(b));
         chk(32'(poff), 32'(p));
         chk(32'(npin), 32'(!(m && !cen)));
         chk(32'(nch), 32'((m && !cen) ? chs : 3'h0));
         apb(1'h0, A_CSR, 32'h0);
         chk(32'(q[5]), 32'(exp_out(m, b, p)));
      end
      // every edge mode, enable held low while mode changes
      apb(1'h1, A_CNV, 32'h0);
      apb(1'h1, A_CSR, 32'h0);
      vp <= 8'h00;
      for (int md = 0; md < 4; md++)
      begin
         apb(1'h1, A_CSR, 32'(md));
         for (int r = 0; r < 2; r++)
         begin
            apb(1'h1, A_CSR, 32'(md) | 32'h10);
            vp <= r ? 8'($urandom_range(127)) : 8'h81 + 8'($urandom_range(126));
            wt(4);
            apb(1'h0, A_CSR, 32'h0);
            chk(32'(q[4]), 32'(exp_flag(md, r == 0)));
         end
      end
      // interrupt request, status, mask and clears
      apb(1'h1, A_IST, 32'h3);
      apb(1'h1, A_MSK, 32'h0);
      apb(1'h1, A_CSR, 32'h10);
      apb(1'h1, A_CSR, 32'h18);
      gie <= 1'h1;
      vp <= 8'hff;
      wt(4);
      chk(32'(req), 32'h1);
      chk(32'(irq), 32'h0);
      gie <= 1'h0;
      wt(1);
      chk(32'(req), 32'h0);
      gie <= 1'h1;
      apb(1'h1, A_CSR, 32'h08);
      wt(1);
      chk(32'(req), 32'h1);
      apb(1'h0, A_IST, 32'h0);
      chk(q, 32'h3);
      apb(1'h1, A_MSK, 32'h1);
      wt(1);
      chk(32'(irq), 32'h1);
      apb(1'h1, A_IST, 32'h1);
      wt(1);
      chk(32'(irq), 32'h0);
      vack <= 1'h1;
      wt(1);
      vack <= 1'h0;
      wt(1);
      chk(32'(req), 32'h0);
      apb(1'h1, A_CSR, 32'h0);
      // pin input buffers
      apb(1'h1, A_IBD, 32'hffffffff);
      apb(1'h0, A_IBD, 32'h0);
      chk(q, 32'h3);
      chk(32'(ppr), 32'h0);
      apb(1'h1, A_IBD, 32'h1);
      wt(3);
      chk(32'(ppr), 32'h2);
      // timer capture routing, count rising edges seen there
      apb(1'h1, A_CSR, 32'h04);
      wt(2);
      c0 = capn;
      repeat (4)
      begin
         vp <= ~vp;
         wt(4);
         chk(32'(cap), 32'(vp[7]));
      end
      chk(32'(capn - c0), 32'h2);
      apb(1'h1, A_CSR, 32'h0);
      wt(1);
      chk(32'(cap), 32'h0);
      wt(2);
      complete_run;
   end
endmodule
